// ### hw/isp_pkg.sv
// constants, register map and field layouts of the flash programming sequencer
package isp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_CTL = 8'h00_bf;
  localparam logic [7:0] IDX_OP_CTL = 8'h00_c7;
  localparam logic [7:0] IDX_ADDR_HI = 8'h00_c4;
  localparam logic [7:0] IDX_ADDR_LO = 8'h00_c5;
  localparam logic [7:0] IDX_DATA = 8'h00_c6;
  localparam logic [7:0] IDX_UNLOCK = 8'h00_f6;
  localparam logic [7:0] IDX_STATUS = 8'h00_c8;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  // unlock key pair
  localparam logic [7:0] KEY_FIRST = 8'h0087;
  localparam logic [7:0] KEY_SECOND = 8'h0059;
  // flash command codes
  localparam logic [3:0] CMD_ERASE = 4'h2;
  localparam logic [3:0] CMD_PROG = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic BANK_APP = 1'b0;
  localparam logic BANK_LOADER = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h0000;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic reboot;     // write: reboot request, read: forced loader boot
    logic [1:0] rsvd;
    logic aux_ram;
    logic [1:0] zero;
    logic loader_loc;
    logic prog_en;
  } isp_mode_ctl_t;

  typedef struct packed {
    logic rsvd;
    logic bank;
    logic oe_n;
    logic ce_n;
    logic [3:0] ctrl;
  } isp_op_ctl_t;

  localparam isp_mode_ctl_t MODE_CTL_RST = '0;
  localparam isp_op_ctl_t OP_CTL_RST = 8'h0030;

  typedef enum logic [1:0] {LOCK_CLOSED, LOCK_HALF, LOCK_OPEN} isp_lock_t;
  typedef enum logic [1:0] {OP_IDLE, OP_PENDING, OP_BUSY} isp_op_t;
endpackage

// ### hw/isp_flash_seq.sv
// in-system flash programming sequencer with an AXI4-Lite register slave
// What this block does
// - 87H then 59H unlocks mode control writes
// - any other unlock value relocks writes
// - mode control is locked after reset
// - program enable isp entry and flash operations need cpu idle
// - program enable enters isp at interrupt wake
// - isp mode fetches from the loader bank after strap entry, else from the bank of the loader location bit
// - switch to the loader bank clears the program counter
// - bits 0, 1, 7 together reboot the cpu
// - bit 7 reads one in forced loader boot
// - bit 4 switches the auxiliary ram
// - loader location bit sets the running bank at program enable isp entry
// - program enable low blocks queuing of every flash operation, read included; one already pending still runs
// - normal operation runs the application bank
// - address from two bytes, ignored by erase
// - data byte feeds program, returns read
// - bit 6 selects the target bank
// - erase 0010, program 0001, read 0000 encoding
`timescale 1ns/1ps
module isp_flash_seq (
  input wire logic ref_clk,                // 125 MHz core clock
  input wire logic rstn,                   // async reset, active low
  input wire logic [11:0] s_axi_awaddr,    // write address
  input wire logic s_axi_awvalid,          // write address valid
  output logic s_axi_awready,              // write address ready
  input wire logic [31:0] s_axi_wdata,     // write data
  input wire logic [3:0] s_axi_wstrb,      // write byte strobes
  input wire logic s_axi_wvalid,           // write data valid
  output logic s_axi_wready,               // write data ready
  output logic [1:0] s_axi_bresp,          // write response
  output logic s_axi_bvalid,               // write response valid
  input wire logic s_axi_bready,           // write response ready
  input wire logic [11:0] s_axi_araddr,    // read address
  input wire logic s_axi_arvalid,          // read address valid
  output logic s_axi_arready,              // read address ready
  output logic [31:0] s_axi_rdata,         // read data
  output logic [1:0] s_axi_rresp,          // read response
  output logic s_axi_rvalid,               // read data valid
  input wire logic s_axi_rready,           // read data ready
  input wire logic cpu_idle,               // cpu sits in idle mode
  input wire logic cpu_wake,               // interrupt wake from idle
  input wire logic loader_boot_strap,      // forced loader boot strap level
  output logic isp_mode,                   // device in programming mode
  output logic code_bank,                  // bank the cpu fetches from
  output logic pc_clear,                   // clear program counter, pulse
  output logic cpu_reset,                  // software reboot, pulse
  output logic aux_ram_on,                 // auxiliary ram enable
  output logic flash_start,                // operation start, pulse
  output logic [3:0] flash_cmd,            // flash control code
  output logic flash_bank,                 // target bank of operation
  output logic flash_output_enable_n,      // flash output enable
  output logic flash_chip_enable_n,        // flash chip enable
  output logic [15:0] flash_addr,          // flash byte address
  output logic [7:0] flash_wdata,          // byte to program
  input wire logic [7:0] flash_rdata,      // byte read back
  input wire logic flash_done              // operation finished, pulse
);
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_fire;
  logic wr_hit;
  logic rd_fire;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  isp_pkg::isp_lock_t lock_q;
  isp_pkg::isp_op_t op_q;
  isp_pkg::isp_mode_ctl_t mode_ctl_q;
  isp_pkg::isp_mode_ctl_t wr_mode;
  isp_pkg::isp_op_ctl_t op_ctl_q;
  logic [7:0] addr_hi_q;
  logic [7:0] addr_lo_q;
  logic [7:0] data_q;
  logic boot_q;
  logic strap_done_q;
  logic soft_rst_q;
  logic op_legal;
  logic op_is_read;

  assign cpu_reset = soft_rst_q;
  assign wr_mode = isp_pkg::isp_mode_ctl_t'(wbyte_q);

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data in either order, then response
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = wr_fire && wlane_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_q <= 1'b0;
      aw_idx_q <= isp_pkg::BYTE_ZERO;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[isp_pkg::IDX_LSB +: 8];
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      w_held_q <= 1'b0;
      wbyte_q <= isp_pkg::BYTE_ZERO;
      wlane_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= isp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_idx_q)
        isp_pkg::IDX_MODE_CTL, isp_pkg::IDX_OP_CTL, isp_pkg::IDX_ADDR_HI,
        isp_pkg::IDX_ADDR_LO, isp_pkg::IDX_DATA, isp_pkg::IDX_UNLOCK,
        isp_pkg::IDX_STATUS: s_axi_bresp <= isp_pkg::RESP_OKAY;
        default: s_axi_bresp <= isp_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side: one cycle from address to data
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[isp_pkg::IDX_LSB +: 8];

  always_comb begin
    rd_hit = 1'b1;
    rd_byte = isp_pkg::BYTE_ZERO;
    unique case (rd_idx)
      isp_pkg::IDX_MODE_CTL: rd_byte = {boot_q, mode_ctl_q[6:0]};
      isp_pkg::IDX_OP_CTL: rd_byte = op_ctl_q;
      isp_pkg::IDX_ADDR_HI: rd_byte = addr_hi_q;
      isp_pkg::IDX_ADDR_LO: rd_byte = addr_lo_q;
      isp_pkg::IDX_DATA: rd_byte = data_q;
      isp_pkg::IDX_UNLOCK: rd_byte = {7'h00, lock_q == isp_pkg::LOCK_OPEN};
      isp_pkg::IDX_STATUS: rd_byte = {4'h0, op_q == isp_pkg::OP_BUSY,
                                      op_q == isp_pkg::OP_PENDING, isp_mode, boot_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= isp_pkg::WORD_ZERO;
      s_axi_rresp <= isp_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? isp_pkg::RESP_OKAY : isp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // unlock sequence for the mode control register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= isp_pkg::LOCK_CLOSED;
    end else if (soft_rst_q) begin
      lock_q <= isp_pkg::LOCK_CLOSED;
    end else if (wr_hit && aw_idx_q == isp_pkg::IDX_UNLOCK) begin
      if (wbyte_q == isp_pkg::KEY_FIRST) begin
        lock_q <= (lock_q == isp_pkg::LOCK_OPEN) ? isp_pkg::LOCK_OPEN : isp_pkg::LOCK_HALF;
      end else if (wbyte_q == isp_pkg::KEY_SECOND) begin
        if (lock_q != isp_pkg::LOCK_CLOSED) begin
          lock_q <= isp_pkg::LOCK_OPEN;
        end
      end else begin
        lock_q <= isp_pkg::LOCK_CLOSED;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode control register and software reboot
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_ctl_q <= isp_pkg::MODE_CTL_RST;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= 1'b0;
      if (soft_rst_q) begin
        mode_ctl_q <= isp_pkg::MODE_CTL_RST;
      end else if (wr_hit && aw_idx_q == isp_pkg::IDX_MODE_CTL &&
                   lock_q == isp_pkg::LOCK_OPEN) begin
        // the reboot bit is a trigger and never stored
        mode_ctl_q <= {1'b0, 2'b00, wr_mode.aux_ram, 2'b00, wr_mode.loader_loc,
                       wr_mode.prog_en};
        soft_rst_q <= wr_mode.reboot && wr_mode.loader_loc && wr_mode.prog_en;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aux_ram_on <= 1'b0;
    end else begin
      aux_ram_on <= mode_ctl_q.aux_ram;
    end
  end

  // strap is caught by a clocked process after release, never by the reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_done_q <= 1'b0;
      boot_q <= 1'b0;
    end else if (soft_rst_q) begin
      boot_q <= 1'b0; // reboot returns to normal operation
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      boot_q <= loader_boot_strap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // programming mode entry and fetch bank
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      isp_mode <= 1'b0;
      code_bank <= isp_pkg::BANK_APP;
      pc_clear <= 1'b0;
    end else begin
      pc_clear <= 1'b0;
      if (soft_rst_q) begin
        isp_mode <= 1'b0;
        code_bank <= isp_pkg::BANK_APP;
      end else if (!strap_done_q && loader_boot_strap) begin
        isp_mode <= 1'b1;
        code_bank <= isp_pkg::BANK_LOADER;
        pc_clear <= 1'b1;
      end else if (!isp_mode && mode_ctl_q.prog_en && cpu_idle && cpu_wake) begin
        isp_mode <= 1'b1;
        code_bank <= mode_ctl_q.loader_loc;
        pc_clear <= mode_ctl_q.loader_loc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flash operation control and target registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op_ctl_q <= isp_pkg::OP_CTL_RST;
      addr_hi_q <= isp_pkg::BYTE_ZERO;
      addr_lo_q <= isp_pkg::BYTE_ZERO;
    end else if (soft_rst_q) begin
      op_ctl_q <= isp_pkg::OP_CTL_RST;
      addr_hi_q <= isp_pkg::BYTE_ZERO;
      addr_lo_q <= isp_pkg::BYTE_ZERO;
    end else if (wr_hit) begin
      if (aw_idx_q == isp_pkg::IDX_OP_CTL) begin
        op_ctl_q <= {1'b0, wbyte_q[6:0]};
      end
      if (aw_idx_q == isp_pkg::IDX_ADDR_HI) begin
        addr_hi_q <= wbyte_q;
      end
      if (aw_idx_q == isp_pkg::IDX_ADDR_LO) begin
        addr_lo_q <= wbyte_q;
      end
    end
  end

  // read fills the data byte when the flash answers; software write otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= isp_pkg::BYTE_ZERO;
    end else if (soft_rst_q) begin
      data_q <= isp_pkg::BYTE_ZERO;
    end else if (op_q == isp_pkg::OP_BUSY && flash_done && op_is_read) begin
      data_q <= flash_rdata;
    end else if (wr_hit && aw_idx_q == isp_pkg::IDX_DATA) begin
      data_q <= wbyte_q;
    end
  end

  // only the three documented command and enable combinations are run, and
  // never against the bank the cpu is fetching from
  always_comb begin
    op_is_read = flash_cmd == isp_pkg::CMD_READ;
    unique case (op_ctl_q.ctrl)
      isp_pkg::CMD_ERASE, isp_pkg::CMD_PROG: op_legal = op_ctl_q.oe_n && !op_ctl_q.ce_n;
      isp_pkg::CMD_READ: op_legal = !op_ctl_q.oe_n && !op_ctl_q.ce_n;
      default: op_legal = 1'b0;
    endcase
  end

  // a write of the control byte in programming mode queues the operation; it
  // runs once the cpu is idle so the cpu sees no bus conflict
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op_q <= isp_pkg::OP_IDLE;
    end else if (soft_rst_q) begin
      op_q <= isp_pkg::OP_IDLE;
    end else begin
      unique case (op_q)
        isp_pkg::OP_IDLE: begin
          if (wr_hit && aw_idx_q == isp_pkg::IDX_OP_CTL && isp_mode &&
              mode_ctl_q.prog_en) begin
            op_q <= isp_pkg::OP_PENDING;
          end
        end
        isp_pkg::OP_PENDING: begin
          if (!op_legal || op_ctl_q.bank == code_bank) begin
            op_q <= isp_pkg::OP_IDLE;
          end else if (cpu_idle) begin
            op_q <= isp_pkg::OP_BUSY;
          end
        end
        isp_pkg::OP_BUSY: begin
          if (flash_done) begin
            op_q <= isp_pkg::OP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flash_start <= 1'b0;
      flash_cmd <= isp_pkg::CMD_READ;
      flash_bank <= isp_pkg::BANK_APP;
      flash_output_enable_n <= 1'b1;
      flash_chip_enable_n <= 1'b1;
      flash_addr <= isp_pkg::ADDR_ZERO;
      flash_wdata <= isp_pkg::BYTE_ZERO;
    end else begin
      flash_start <= 1'b0;
      if (op_q == isp_pkg::OP_PENDING && op_legal && op_ctl_q.bank != code_bank &&
          cpu_idle && !soft_rst_q) begin
        flash_start <= 1'b1;
        flash_cmd <= op_ctl_q.ctrl;
        flash_bank <= op_ctl_q.bank;
        flash_output_enable_n <= op_ctl_q.oe_n;
        flash_chip_enable_n <= op_ctl_q.ce_n;
        flash_addr <= (op_ctl_q.ctrl == isp_pkg::CMD_ERASE) ? isp_pkg::ADDR_ZERO
                      : {addr_hi_q, addr_lo_q};
        flash_wdata <= data_q;
      end else if (op_q != isp_pkg::OP_BUSY || flash_done) begin
        flash_output_enable_n <= 1'b1;
        flash_chip_enable_n <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  bad_key_relock_a: assert property (wr_hit && aw_idx_q == isp_pkg::IDX_UNLOCK &&
    wbyte_q != isp_pkg::KEY_FIRST && wbyte_q != isp_pkg::KEY_SECOND
    |=> lock_q == isp_pkg::LOCK_CLOSED) else $error("unlock not closed by bad key");
  key_pair_open_a: assert property (lock_q == isp_pkg::LOCK_HALF && wr_hit &&
    aw_idx_q == isp_pkg::IDX_UNLOCK && wbyte_q == isp_pkg::KEY_SECOND && !soft_rst_q
    |=> lock_q == isp_pkg::LOCK_OPEN) else $error("key pair did not open");
  locked_write_held_a: assert property (wr_hit && aw_idx_q == isp_pkg::IDX_MODE_CTL &&
    lock_q != isp_pkg::LOCK_OPEN && !soft_rst_q |=> $stable(mode_ctl_q))
    else $error("locked write changed mode control");
  isp_entry_cause_a: assert property ($rose(isp_mode) && $past(strap_done_q) |->
    $past(cpu_idle && cpu_wake && mode_ctl_q.prog_en)) else $error("isp entry without wake");
  pc_clear_bank_a: assert property (pc_clear |->
    isp_mode && code_bank == isp_pkg::BANK_LOADER) else $error("pc clear outside loader switch");
  reboot_seq_a: assert property (wr_hit && aw_idx_q == isp_pkg::IDX_MODE_CTL &&
    lock_q == isp_pkg::LOCK_OPEN && wbyte_q[7] && wbyte_q[1] && wbyte_q[0] && !soft_rst_q
    |=> cpu_reset ##1 !isp_mode && code_bank == isp_pkg::BANK_APP)
    else $error("reboot sequence wrong");
  boot_bit_read_a: assert property (rd_fire && rd_idx == isp_pkg::IDX_MODE_CTL && boot_q &&
    !soft_rst_q |=> s_axi_rdata[7]) else $error("bit 7 not read in loader boot");
  aux_ram_follow_a: assert property (##1 aux_ram_on == $past(mode_ctl_q.aux_ram))
    else $error("aux ram enable wrong");
  op_needs_enable_a: assert property (flash_start |-> $past(mode_ctl_q.prog_en) &&
    $past(cpu_idle, 1)) else $error("flash op without enable or idle");
  erase_addr_zero_a: assert property (flash_start && flash_cmd == isp_pkg::CMD_ERASE |->
    flash_addr == isp_pkg::ADDR_ZERO && flash_output_enable_n) else $error("erase setup wrong");
  read_enables_a: assert property (flash_start && flash_cmd == isp_pkg::CMD_READ |->
    !flash_output_enable_n && !flash_chip_enable_n) else $error("read enables wrong");
  read_capture_a: assert property (op_q == isp_pkg::OP_BUSY && flash_done && op_is_read &&
    !soft_rst_q |=> data_q == $past(flash_rdata)) else $error("read byte not captured");

  isp_entry_c: cover property ($rose(isp_mode) && $past(strap_done_q));
  read_done_c: cover property (op_q == isp_pkg::OP_BUSY && flash_done && op_is_read);
  reboot_c: cover property (cpu_reset);
endmodule

// ### test/isp_flash_model.sv
// behavioural model of the two-bank flash array behind the sequencer
`timescale 1ns/1ps
module isp_flash_model #(
  parameter int DELAY = 3,
  parameter logic [7:0] ERASED = 8'hff
) (
  input wire logic ref_clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic flash_start, // operation start pulse
  input wire logic [3:0] flash_cmd, // control code
  input wire logic flash_bank, // target bank
  input wire logic flash_output_enable_n, // output enable, active low
  input wire logic flash_chip_enable_n, // chip enable, active low
  input wire logic [15:0] flash_addr, // byte address
  input wire logic [7:0] flash_wdata, // byte to program
  output logic [7:0] flash_rdata, // byte read back
  output logic flash_done // operation finished pulse
);
  logic [7:0] app_q [logic [15:0]];
  logic [7:0] ldr_q [logic [15:0]];
  int wait_q;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q = 0;
      flash_done <= 1'b0;
      flash_rdata <= 8'h5a;
    end else begin
      flash_done <= 1'b0;
      // a stale byte keeps changing so it can never pass for a fresh read
      flash_rdata <= ~flash_rdata;
      if (flash_start) begin
        wait_q = DELAY;
      end else if (wait_q > 0) begin
        wait_q = wait_q - 1;
        if (wait_q == 0 && !flash_chip_enable_n) begin
          flash_done <= 1'b1;
          case (flash_cmd)
            4'h0: begin
              if (!flash_output_enable_n && flash_bank) begin
                flash_rdata <= ldr_q.exists(flash_addr) ? ldr_q[flash_addr] : ERASED;
              end else if (!flash_output_enable_n) begin
                flash_rdata <= app_q.exists(flash_addr) ? app_q[flash_addr] : ERASED;
              end
            end
            4'h1: begin
              if (flash_bank) ldr_q[flash_addr] = flash_wdata;
              else app_q[flash_addr] = flash_wdata;
            end
            4'h2: begin
              if (flash_bank) ldr_q.delete();
              else app_q.delete();
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule

// ### test/test_isp_flash_seq.sv
// self-checking bench of the flash programming sequencer
`timescale 1ns/1ps
module test_isp_flash_seq;
  typedef struct packed {logic w; logic [7:0] idx; logic [7:0] d; logic [1:0] rsp;} isp_row_t;
  logic ref_clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cpu_idle = 1'b0, cpu_wake = 1'b0, strap = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awready, wready, bvalid, arready, rvalid, isp_mode, code_bank, pc_clear, cpu_reset;
  logic aux_ram_on, flash_start, flash_bank, oe_n, ce_n, flash_done;
  logic [1:0] bresp, rresp;
  logic [3:0] flash_cmd;
  logic [15:0] flash_addr;
  logic [7:0] flash_wdata, flash_rdata;
  logic [30:0] cap;
  int fails = 0, checks = 0, cyc = 0, npc = 0, nrst = 0, nst = 0, ndone = 0;
  isp_row_t rows [20] = '{
    '{0, isp_pkg::IDX_MODE_CTL, 8'h00, 2'h0},
    '{1, isp_pkg::IDX_MODE_CTL, 8'h13, 2'h0}, '{0, isp_pkg::IDX_MODE_CTL, 8'h00, 2'h0},
    '{1, isp_pkg::IDX_UNLOCK, 8'h87, 2'h0}, '{1, isp_pkg::IDX_UNLOCK, 8'h59, 2'h0},
    '{0, isp_pkg::IDX_UNLOCK, 8'h01, 2'h0}, '{1, isp_pkg::IDX_MODE_CTL, 8'h7f, 2'h0},
    '{0, isp_pkg::IDX_MODE_CTL, 8'h13, 2'h0}, '{1, isp_pkg::IDX_UNLOCK, 8'h87, 2'h0},
    '{1, isp_pkg::IDX_UNLOCK, 8'h00, 2'h0}, '{0, isp_pkg::IDX_UNLOCK, 8'h00, 2'h0},
    '{1, isp_pkg::IDX_MODE_CTL, 8'h00, 2'h0}, '{0, isp_pkg::IDX_MODE_CTL, 8'h13, 2'h0},
    '{0, 8'h10, 8'h00, 2'h2}, '{0, isp_pkg::IDX_OP_CTL, 8'h30, 2'h0},
    '{1, isp_pkg::IDX_ADDR_HI, 8'h12, 2'h0}, '{1, isp_pkg::IDX_ADDR_LO, 8'h34, 2'h0},
    '{0, isp_pkg::IDX_ADDR_LO, 8'h34, 2'h0}, '{1, isp_pkg::IDX_DATA, 8'ha5, 2'h0},
    '{0, isp_pkg::IDX_DATA, 8'ha5, 2'h0}};

  isp_flash_seq u_dut (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_idle(cpu_idle),
    .cpu_wake(cpu_wake), .loader_boot_strap(strap), .isp_mode(isp_mode),
    .code_bank(code_bank), .pc_clear(pc_clear), .cpu_reset(cpu_reset),
    .aux_ram_on(aux_ram_on), .flash_start(flash_start), .flash_cmd(flash_cmd),
    .flash_bank(flash_bank), .flash_output_enable_n(oe_n), .flash_chip_enable_n(ce_n),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
    .flash_done(flash_done));
  isp_flash_model u_flash (.ref_clk(ref_clk), .rstn(rstn), .flash_start(flash_start),
    .flash_cmd(flash_cmd), .flash_bank(flash_bank), .flash_output_enable_n(oe_n),
    .flash_chip_enable_n(ce_n), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata), .flash_done(flash_done));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pulses are counted on the falling edge, away from the edge that launches them
  always @(negedge ref_clk) begin
    cyc++;
    if (pc_clear) npc++;
    if (cpu_reset) nrst++;
    if (flash_done) ndone++;
    if (flash_start) nst++;
    if (flash_start) cap = {flash_cmd, flash_bank, oe_n, ce_n, flash_addr, flash_wdata};
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apply_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d, logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    cmp(bresp, rsp);
  endtask
  task automatic rd(logic [7:0] idx, logic [7:0] d, logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    cmp(rdata, {24'h00_0000, d});
    cmp(rresp, rsp);
  endtask
  // queue an operation with the cpu awake, then let it run once the cpu idles
  task automatic op(logic [7:0] v, int st);
    int s0, d0, i;
    wr(isp_pkg::IDX_OP_CTL, v, isp_pkg::RESP_OKAY);
    s0 = nst;
    d0 = ndone;
    repeat (4) @(posedge ref_clk);
    cmp(nst - s0, 0);
    cpu_idle <= 1'b1;
    for (i = 0; i < 30 && ndone == d0; i++) @(posedge ref_clk);
    cpu_idle <= 1'b0;
    @(posedge ref_clk);
    cmp(nst - s0, st);
    cmp({oe_n, ce_n}, 2'b11);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    apply_reset();
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].idx, rows[i].d, rows[i].rsp);
      else rd(rows[i].idx, rows[i].d, rows[i].rsp);
    end
    cmp(aux_ram_on, 1'b1);
    @(posedge ref_clk);
    cpu_idle <= 1'b1;
    cpu_wake <= 1'b1;
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
    cpu_wake <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp({isp_mode, code_bank}, 2'b11);
    cmp(npc, 1);
    op(8'h21, 1);
    cmp(cap, {4'h1, 3'b010, 16'h1234, 8'ha5});
    wr(isp_pkg::IDX_DATA, 8'h00, isp_pkg::RESP_OKAY);
    op(8'h00, 1);
    cmp(cap[30:8], {4'h0, 3'b000, 16'h1234});
    rd(isp_pkg::IDX_DATA, 8'ha5, isp_pkg::RESP_OKAY);
    op(8'h22, 1);
    cmp(cap[30:8], {4'h2, 3'b010, 16'h0000});
    op(8'h00, 1);
    rd(isp_pkg::IDX_DATA, 8'hff, isp_pkg::RESP_OKAY);
    op(8'h61, 0);
    wr(isp_pkg::IDX_UNLOCK, 8'h87, isp_pkg::RESP_OKAY);
    wr(isp_pkg::IDX_UNLOCK, 8'h59, isp_pkg::RESP_OKAY);
    wr(isp_pkg::IDX_MODE_CTL, 8'h83, isp_pkg::RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    cmp(nrst, 1);
    cmp({isp_mode, code_bank}, 2'b00);
    rd(isp_pkg::IDX_MODE_CTL, 8'h00, isp_pkg::RESP_OKAY);
    op(8'h21, 0);
    strap <= 1'b1;
    apply_reset();
    cmp({isp_mode, code_bank}, 2'b11);
    rd(isp_pkg::IDX_MODE_CTL, 8'h80, isp_pkg::RESP_OKAY);
    rd(isp_pkg::IDX_STATUS, 8'h03, isp_pkg::RESP_OKAY);
    cmp(npc, 2);
    end_of_test();
  end
endmodule
